// ===== rtl/cfg_header_pkg.sv
// Constants and carrier types for the configuration header block.
// Assumes one system clock and a simple config read/write access port.
package cfg_header_pkg;

	// Doubleword offsets (byte addresses)
	localparam logic [7:0] OFF_IDENT     = 8'h00;
	localparam logic [7:0] OFF_COMMAND   = 8'h04;
	localparam logic [7:0] OFF_CLASS     = 8'h08;
	localparam logic [7:0] OFF_MISCB     = 8'h0c;
	localparam logic [7:0] OFF_OP_BASE   = 8'h10;
	localparam logic [7:0] OFF_EXT_BASE  = 8'h14;
	localparam logic [7:0] OFF_CIS_BASE  = 8'h18;
	localparam logic [7:0] OFF_SUBSYS    = 8'h2c;
	localparam logic [7:0] OFF_CAP_PTR   = 8'h34;
	localparam logic [7:0] OFF_INTLAT    = 8'h3c;
	localparam logic [7:0] OFF_HOST_CTL  = 8'h40;
	localparam logic [7:0] OFF_PWR_CAP   = 8'h44;
	localparam logic [7:0] OFF_PWR_CSR   = 8'h48;
	localparam logic [7:0] OFF_MISC_DEV  = 8'hf0;
	localparam logic [7:0] OFF_LINK_FEAT = 8'hf4;
	localparam logic [7:0] OFF_SUB_ALIAS = 8'hf8;
	localparam logic [7:0] OFF_GPIN      = 8'hfc;

	// Command field positions
	localparam int CMD_IO_SPACE   = 0;
	localparam int CMD_MEM_SPACE  = 1;
	localparam int CMD_INITIATOR  = 2;
	localparam int CMD_SPECIAL    = 3;
	localparam int CMD_WR_INVAL   = 4;
	localparam int CMD_PALETTE    = 5;
	localparam int CMD_PARITY     = 6;
	localparam int CMD_STEPPING   = 7;
	localparam int CMD_SYS_ERR    = 8;
	localparam int CMD_BACK2BACK  = 9;

	// Writable command bits: 8, 6, 4, 2, 1
	localparam logic [15:0] CMD_WR_MASK  = 16'h0156;
	localparam logic [15:0] CMD_RESET    = 16'h0000;

	// Status word as read back next to the command word
	localparam logic [15:0] STATUS_FIXED = 16'h0210;

	// Identity codes: arbitrary neutral values
	localparam logic [15:0] MAKER_ID_DEF = 16'h1234;
	localparam logic [15:0] PART_ID_DEF  = 16'h5678;

	// Read-only header defaults
	localparam logic [31:0] CLASS_REV_DEF = 32'h0c001000;
	localparam logic [31:0] HDR_MISC_DEF  = 32'h00000000;
	localparam logic [31:0] SUBSYS_DEF    = 32'h00000000;
	localparam logic [31:0] CAP_PTR_DEF   = 32'h00000044;
	localparam logic [31:0] PWR_CAP_DEF   = 32'h00000001;
	localparam logic [31:0] INT_PIN_DEF   = 32'h00000100;

	// Base-address windows: low address bits fixed at zero
	localparam logic [31:0] OP_BASE_MASK  = 32'hfffff800;
	localparam logic [31:0] EXT_BASE_MASK = 32'hffffc000;
	localparam logic [31:0] CIS_BASE_MASK = 32'hfffff800;
	localparam logic [31:0] INTLINE_MASK  = 32'h000000ff;
	localparam logic [31:0] ALL_WR_MASK   = 32'hffffffff;
	localparam logic [31:0] ZERO_WORD     = 32'h00000000;

	// Number of plain read/write storage words
	localparam int NUM_RW = 10;

	// Config access request from the host bridge side
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	// Decoded command enables presented to the PCI core
	typedef struct packed {
		logic system_error_drive_enable;
		logic parity_report_enable;
		logic write_invalidate_enable;
		logic bus_initiator_enable;
		logic memory_space_response;
	} cmd_enables_t;

endpackage : cfg_header_pkg

// ===== rtl/cfg_header.sv
// Type-zero configuration header with command register and header map.
// Assumes config cycles are already decoded to a single-cycle access strobe.
//
// Function
// R1 - Single configuration function; PCI or CardBus mode chosen by a strap.
// R2 - Standard type-zero header; device-specific words after the predefined area.
// R3 - Read-only 16-bit maker code at offset 0; writes have no effect.
// R4 - Read-only 16-bit part code at offset 2; writes ignored.
// R5 - 16-bit command register at offset 4, all zeros after reset.
// R6 - Command bits 15..10 reserved, read zero, ignore writes.
// R7 - Bit 9 back-to-back enable reads zero; never generate such transactions.
// R8 - Bit 8 read/write; enables the system error driver.
// R9 - Bit 7 stepping control hardwired zero.
// R10 - Bit 6 read/write; parity error drive allowed only while set.
// R11 - Bit 5 palette snoop reads zero.
// R12 - Bit 4 read/write; selects write-and-invalidate over plain memory writes.
// R13 - Bit 3 special cycle enable reads zero; special cycles ignored.
// R14 - Bit 2 read/write; bus requests only while set.
// R15 - Bit 1 read/write; memory accesses claimed only while set.
// R16 - Bit 0 I/O enable reads zero; no I/O cycles claimed.
// R17 - Three base-address registers at successive doublewords.
// R18 - Device-specific misc configuration word in the user region.
// R19 - Reserved offsets read zero; writes complete with no effect.
`timescale 1ns/10ps

module cfg_header (
	input  wire logic                         clk_sys_i,      // System clock
	input  wire logic                         rst_n_i,        // Sync reset, active low
	input  wire logic                         clk_en_i,       // Freezes all state when low
	input  wire logic                         cardbus_strap_i, // Bus mode strap
	input  wire cfg_header_pkg::cfg_req_t     cfg_req_i,      // Config access
	input  wire logic                         mem_hit_i,      // Memory decode hit
	input  wire logic                         io_hit_i,       // I/O decode hit
	input  wire logic                         special_cyc_i,  // Special cycle seen
	input  wire logic                         addr_par_err_i, // Address parity error
	input  wire logic                         data_par_err_i, // Data parity error
	input  wire logic                         mst_req_i,      // Core wants the bus
	input  wire logic                         mst_write_i,    // Core write is burst-aligned
	output logic [31:0]                       cfg_rdata_o,    // Read data
	output logic                              cfg_ack_o,      // Access done pulse
	output logic                              cardbus_mode_o, // Latched bus mode
	output cfg_header_pkg::cmd_enables_t      cmd_en_o,       // Command enables
	output logic                              mem_claim_o,    // Claim memory access
	output logic                              io_claim_o,     // Claim I/O access
	output logic                              serr_assert_o,  // Drive system error
	output logic                              perr_assert_o,  // Drive parity error
	output logic                              bus_req_o,      // Bus request
	output logic                              mwi_cmd_o,      // Use write-and-invalidate
	output logic                              fast_b2b_o      // Fast back-to-back use
);

	////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [15:0]                 cmd_q;
	logic [15:0]                 cmd_d;
	logic [31:0]                 rw_q [cfg_header_pkg::NUM_RW];
	logic [31:0]                 rw_d [cfg_header_pkg::NUM_RW];
	logic                        mode_q;
	logic                        mode_taken_q;

	// Addresses and write masks for the plain storage words
	logic [7:0]                  rw_addr [cfg_header_pkg::NUM_RW];
	logic [31:0]                 rw_mask [cfg_header_pkg::NUM_RW];

	assign rw_addr[0] = cfg_header_pkg::OFF_OP_BASE;   // R17
	assign rw_addr[1] = cfg_header_pkg::OFF_EXT_BASE;  // R17
	assign rw_addr[2] = cfg_header_pkg::OFF_CIS_BASE;  // R17
	assign rw_addr[3] = cfg_header_pkg::OFF_INTLAT;
	assign rw_addr[4] = cfg_header_pkg::OFF_HOST_CTL;
	assign rw_addr[5] = cfg_header_pkg::OFF_PWR_CSR;
	assign rw_addr[6] = cfg_header_pkg::OFF_MISC_DEV;  // R18
	assign rw_addr[7] = cfg_header_pkg::OFF_LINK_FEAT;
	assign rw_addr[8] = cfg_header_pkg::OFF_SUB_ALIAS;
	assign rw_addr[9] = cfg_header_pkg::OFF_GPIN;

	assign rw_mask[0] = cfg_header_pkg::OP_BASE_MASK;
	assign rw_mask[1] = cfg_header_pkg::EXT_BASE_MASK;
	assign rw_mask[2] = cfg_header_pkg::CIS_BASE_MASK;
	assign rw_mask[3] = cfg_header_pkg::INTLINE_MASK;
	assign rw_mask[4] = cfg_header_pkg::ALL_WR_MASK;
	assign rw_mask[5] = cfg_header_pkg::ALL_WR_MASK;
	assign rw_mask[6] = cfg_header_pkg::ALL_WR_MASK;
	assign rw_mask[7] = cfg_header_pkg::ALL_WR_MASK;
	assign rw_mask[8] = cfg_header_pkg::ALL_WR_MASK;
	assign rw_mask[9] = cfg_header_pkg::ALL_WR_MASK;

	////////////////////////////////////////////////////////////////////////////
	// Write path

	wire                         wr_cmd;
	wire [31:0]                  be_mask;
	wire [15:0]                  cmd_wmask;

	assign be_mask = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}},
	                  {8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};
	assign wr_cmd  = cfg_req_i.wr && (cfg_req_i.addr == cfg_header_pkg::OFF_COMMAND);
	// Only bits 8, 6, 4, 2, 1 take writes; others stay zero
	assign cmd_wmask = cfg_header_pkg::CMD_WR_MASK & be_mask[15:0]; // R6 R7 R9 R11 R13 R16
	assign cmd_d = wr_cmd ? ((cmd_q & ~cmd_wmask) | (cfg_req_i.wdata[15:0] & cmd_wmask))
	                      : cmd_q; // R5 R8 R10 R12 R14 R15

	genvar gi;
	generate
		for (gi = 0; gi < cfg_header_pkg::NUM_RW; gi++) begin : g_rw
			wire         hit;
			wire [31:0]  m;
			assign hit = cfg_req_i.wr && (cfg_req_i.addr == rw_addr[gi]);
			assign m   = rw_mask[gi] & be_mask;
			assign rw_d[gi] = hit ? ((rw_q[gi] & ~m) | (cfg_req_i.wdata & m)) : rw_q[gi];
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					rw_q[gi] <= cfg_header_pkg::ZERO_WORD;
				end else if (clk_en_i) begin
					rw_q[gi] <= rw_d[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cmd_q <= cfg_header_pkg::CMD_RESET; // R5
		end else if (clk_en_i) begin
			cmd_q <= cmd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus mode strap

	// Strap caught once on the first enabled edge after reset release
	wire                         mode_take;

	// Later strap changes are ignored so the buffer mode cannot flip mid-run
	assign mode_take = clk_en_i && !mode_taken_q;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mode_q <= 1'b0;
		end else if (mode_take) begin
			mode_q <= cardbus_strap_i; // R1
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mode_taken_q <= 1'b0;
		end else if (mode_take) begin
			mode_taken_q <= 1'b1; // R1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path

	logic [31:0]                 rd_mux;
	logic [31:0]                 rw_rd;
	wire  [31:0]                 cmd_stat_word;

	assign cmd_stat_word = {cfg_header_pkg::STATUS_FIXED, cmd_q};

	always_comb begin
		rw_rd = cfg_header_pkg::ZERO_WORD;
		for (int i = 0; i < cfg_header_pkg::NUM_RW; i++) begin
			if (cfg_req_i.addr == rw_addr[i]) begin
				rw_rd = rw_q[i];
			end
		end
	end

	always_comb begin
		case (cfg_req_i.addr)
			cfg_header_pkg::OFF_IDENT:
				rd_mux = {cfg_header_pkg::PART_ID_DEF, cfg_header_pkg::MAKER_ID_DEF}; // R3 R4
			cfg_header_pkg::OFF_COMMAND:  rd_mux = cmd_stat_word;
			cfg_header_pkg::OFF_CLASS:    rd_mux = cfg_header_pkg::CLASS_REV_DEF; // R2
			cfg_header_pkg::OFF_MISCB:    rd_mux = cfg_header_pkg::HDR_MISC_DEF;
			cfg_header_pkg::OFF_SUBSYS:   rd_mux = cfg_header_pkg::SUBSYS_DEF;
			cfg_header_pkg::OFF_CAP_PTR:  rd_mux = cfg_header_pkg::CAP_PTR_DEF;
			cfg_header_pkg::OFF_PWR_CAP:  rd_mux = cfg_header_pkg::PWR_CAP_DEF;
			cfg_header_pkg::OFF_INTLAT:   rd_mux = rw_rd | cfg_header_pkg::INT_PIN_DEF;
			default:                      rd_mux = rw_rd; // R19
		endcase
	end

	wire  [31:0]                 rdata_d;
	wire                         ack_d;

	// Data is zero outside a read so a stray sample never shows stale words
	assign rdata_d = cfg_req_i.rd ? rd_mux : cfg_header_pkg::ZERO_WORD;
	assign ack_d   = cfg_req_i.rd || cfg_req_i.wr;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cfg_rdata_o <= cfg_header_pkg::ZERO_WORD;
		end else if (clk_en_i) begin
			cfg_rdata_o <= rdata_d; // R19
		end
	end

	// Every access, mapped or not, completes in one cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cfg_ack_o <= 1'b0;
		end else if (clk_en_i) begin
			cfg_ack_o <= ack_d; // R19
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command effects on the bus interface

	wire                         mem_en;
	wire                         par_en;
	wire                         serr_en;
	wire                         init_en;
	wire                         mwi_en;

	assign mem_en  = cmd_q[cfg_header_pkg::CMD_MEM_SPACE];
	assign par_en  = cmd_q[cfg_header_pkg::CMD_PARITY];
	assign serr_en = cmd_q[cfg_header_pkg::CMD_SYS_ERR];
	assign init_en = cmd_q[cfg_header_pkg::CMD_INITIATOR];
	assign mwi_en  = cmd_q[cfg_header_pkg::CMD_WR_INVAL];

	cfg_header_pkg::cmd_enables_t cmd_en_d;
	wire                         mem_claim_d;
	wire                         io_claim_d;
	wire                         serr_assert_d;
	wire                         perr_assert_d;
	wire                         bus_req_d;
	wire                         mwi_cmd_d;
	wire                         fast_b2b_d;

	assign cmd_en_d      = {serr_en, par_en, mwi_en, init_en, mem_en};
	assign mem_claim_d   = mem_hit_i && mem_en; // R15
	// No I/O window exists, so the hit is never claimed
	assign io_claim_d    = 1'b0 && io_hit_i; // R16
	assign serr_assert_d = serr_en && addr_par_err_i; // R8
	assign perr_assert_d = par_en && data_par_err_i; // R10
	assign bus_req_d     = init_en && mst_req_i; // R14
	// Invalidate form only for writes the core may start at all
	assign mwi_cmd_d     = init_en && mwi_en && mst_write_i; // R12
	// Special cycles are ignored and never open a back-to-back chain
	assign fast_b2b_d    = 1'b0 && special_cyc_i; // R7 R13

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cardbus_mode_o <= 1'b0;
		end else if (clk_en_i) begin
			cardbus_mode_o <= mode_q; // R1
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cmd_en_o <= '0;
		end else if (clk_en_i) begin
			cmd_en_o <= cmd_en_d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mem_claim_o <= 1'b0;
		end else if (clk_en_i) begin
			mem_claim_o <= mem_claim_d; // R15
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			io_claim_o <= 1'b0;
		end else if (clk_en_i) begin
			io_claim_o <= io_claim_d; // R16
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			serr_assert_o <= 1'b0;
		end else if (clk_en_i) begin
			serr_assert_o <= serr_assert_d; // R8
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			perr_assert_o <= 1'b0;
		end else if (clk_en_i) begin
			perr_assert_o <= perr_assert_d; // R10
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bus_req_o <= 1'b0;
		end else if (clk_en_i) begin
			bus_req_o <= bus_req_d; // R14
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mwi_cmd_o <= 1'b0;
		end else if (clk_en_i) begin
			mwi_cmd_o <= mwi_cmd_d; // R12
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			fast_b2b_o <= 1'b0;
		end else if (clk_en_i) begin
			fast_b2b_o <= fast_b2b_d; // R7 R13
		end
	end

endmodule : cfg_header

// ===== test/cfg_header_checker.sv
// Concurrent checks on the config header ports.
// Bound into cfg_header; sees its ports only.
`timescale 1ns/10ps
module cfg_header_checker (
	input wire logic                         clk_sys_i,     // Clock
	input wire logic                         rst_n_i,       // Reset
	input wire logic                         clk_en_i,      // Enable
	input wire cfg_header_pkg::cfg_req_t     cfg_req_i,     // Access
	input wire logic [31:0]                  cfg_rdata_o,   // Read data
	input wire logic                         cfg_ack_o,     // Done
	input wire cfg_header_pkg::cmd_enables_t cmd_en_o,      // Enables
	input wire logic                         mem_claim_o,   // Mem claim
	input wire logic                         io_claim_o,    // I/O claim
	input wire logic                         serr_assert_o, // Sys error
	input wire logic                         perr_assert_o, // Parity
	input wire logic                         bus_req_o,     // Request
	input wire logic                         mwi_cmd_o,     // Invalidate
	input wire logic                         fast_b2b_o     // Back-to-back
);
////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	wire logic take = clk_en_i && (cfg_req_i.rd || cfg_req_i.wr);
	sequence s_read(logic [7:0] a);
		clk_en_i && cfg_req_i.rd && cfg_req_i.addr == a ##1 cfg_ack_o;
	endsequence
	property p_ack;
		take |=> cfg_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("access not acknowledged");
	property p_ident;
		s_read(cfg_header_pkg::OFF_IDENT) |->
			cfg_rdata_o == {cfg_header_pkg::PART_ID_DEF, cfg_header_pkg::MAKER_ID_DEF};
	endproperty
	a_ident: assert property (p_ident) else $error("identity word wrong");
	property p_cmd;
		s_read(cfg_header_pkg::OFF_COMMAND) |->
			(cfg_rdata_o[15:0] & ~cfg_header_pkg::CMD_WR_MASK) == 16'h0000;
	endproperty
	a_cmd: assert property (p_cmd) else $error("fixed command bit set");
	property p_io;
		!io_claim_o;
	endproperty
	a_io: assert property (p_io) else $error("I/O cycle claimed");
	property p_fbb;
		!fast_b2b_o;
	endproperty
	a_fbb: assert property (p_fbb) else $error("back-to-back used");
	property p_gate(logic o, logic e);
		o |-> e || $past(e);
	endproperty
	a_mem: assert property (p_gate(mem_claim_o, cmd_en_o.memory_space_response))
		else $error("claim without enable");
	a_serr: assert property (p_gate(serr_assert_o, cmd_en_o.system_error_drive_enable))
		else $error("system error without enable");
	a_perr: assert property (p_gate(perr_assert_o, cmd_en_o.parity_report_enable))
		else $error("parity drive without enable");
	a_req: assert property (p_gate(bus_req_o, cmd_en_o.bus_initiator_enable))
		else $error("request without enable");
	a_mwi: assert property (p_gate(mwi_cmd_o, cmd_en_o.write_invalidate_enable))
		else $error("invalidate without enable");
endmodule : cfg_header_checker

bind cfg_header cfg_header_checker cfg_header_checker_inst (.*);

// ===== test/cfg_host_model.sv
// Host bridge model issuing config reads and writes.
// One-cycle strobes launched on the rising edge; ack awaited 8 cycles.
`timescale 1ns/10ps
module cfg_host_model (
	input  wire logic                clk_sys_i,   // Clock
	input  wire logic [31:0]         cfg_rdata_i, // Read data
	input  wire logic                cfg_ack_i,   // Done
	output cfg_header_pkg::cfg_req_t cfg_req_o    // Access
);
	int n_lost;
	initial begin
		cfg_req_o = '0;
		n_lost = 0;
	end
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rdat);
		bit seen;
		seen = 0;
		rdat = '0;
		@(posedge clk_sys_i);
		cfg_req_o <= '{rd, !rd, a, be, wd};
		@(posedge clk_sys_i);
		cfg_req_o.rd <= 1'b0;
		cfg_req_o.wr <= 1'b0;
		// Stale data would hide a missed byte enable
		cfg_req_o.wdata <= ~wd;
		// Sample mid-cycle, where the one-cycle ack and data are settled
		for (int i = 0; i < 8 && !seen; i++) begin
			@(negedge clk_sys_i);
			seen = (cfg_ack_i === 1'b1);
			rdat = cfg_rdata_i;
		end
		if (!seen)
			n_lost++;
	endtask : xfer
endmodule : cfg_host_model

// ===== test/cfg_header_tb_top.sv
// Self-checking bench for the config header.
// Host model drives config cycles; event inputs are first raised on a falling edge, later changed on rising edges.
`timescale 1ns/10ps
module cfg_header_tb_top;
	typedef struct packed {
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_t;
	logic clk_sys_i, rst_n_i, clk_en_i, cardbus_strap_i, cfg_ack_o, cardbus_mode_o;
	logic mem_hit_i, io_hit_i, special_cyc_i, addr_par_err_i, data_par_err_i;
	logic mst_req_i, mst_write_i, mem_claim_o, io_claim_o, serr_assert_o;
	logic perr_assert_o, bus_req_o, mwi_cmd_o, fast_b2b_o;
	logic [31:0] cfg_rdata_o, rd;
	cfg_header_pkg::cfg_req_t     cfg_req_i;
	cfg_header_pkg::cmd_enables_t cmd_en_o;
	int n_mismatch, n_compared;
	row_t rows [11];
	cfg_header cfg_header_inst (.*);
	cfg_host_model cfg_host_model_inst (.clk_sys_i(clk_sys_i), .cfg_rdata_i(cfg_rdata_o),
		.cfg_ack_i(cfg_ack_o), .cfg_req_o(cfg_req_i));
////////////////////////////////////////
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rw(input logic r, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		cfg_host_model_inst.xfer(r, a, be, wd, rd);
		if (cfg_host_model_inst.n_lost != 0) begin
			n_mismatch++;
			conclude();
		end
	endtask : rw
	task automatic events(input logic [31:0] cmd, input logic [31:0] exp);
		rw(1'b0, cfg_header_pkg::OFF_COMMAND, 4'hf, cmd);
		repeat (2) @(posedge clk_sys_i);
		chk({cmd_en_o, mem_claim_o, io_claim_o, serr_assert_o, perr_assert_o, bus_req_o,
			mwi_cmd_o, fast_b2b_o}, exp);
	endtask : events
////////////////////////////////////////
	initial begin
		{mem_hit_i, io_hit_i, special_cyc_i, addr_par_err_i} = '0;
		{data_par_err_i, mst_req_i, mst_write_i, rst_n_i} = '0;
		clk_en_i = 1'b1;
		cardbus_strap_i = 1'b1;
		n_mismatch = 0;
		n_compared = 0;
		rows = '{'{8'h04, 4'hf, 32'hffffffff, 32'h02100156},
			'{8'h04, 4'h1, 32'h00000000, 32'h02100100},
			'{8'h04, 4'hf, 32'h00000000, 32'h02100000},
			'{8'h00, 4'hf, 32'hffffffff,
				{cfg_header_pkg::PART_ID_DEF, cfg_header_pkg::MAKER_ID_DEF}},
			'{8'h08, 4'hf, 32'hffffffff, cfg_header_pkg::CLASS_REV_DEF},
			'{8'h10, 4'hf, 32'hffffffff, cfg_header_pkg::OP_BASE_MASK},
			'{8'h14, 4'hf, 32'hffffffff, cfg_header_pkg::EXT_BASE_MASK},
			'{8'h18, 4'hf, 32'hffffffff, cfg_header_pkg::CIS_BASE_MASK},
			'{8'h1c, 4'hf, 32'hffffffff, 32'h00000000},
			'{8'ha0, 4'hf, 32'hffffffff, 32'h00000000},
			'{8'hf0, 4'hf, 32'ha5a5a5a5, 32'ha5a5a5a5}};
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk({31'h0, cardbus_mode_o}, 32'h1);
		rw(1'b1, cfg_header_pkg::OFF_COMMAND, 4'hf, 32'h0);
		chk(rd, 32'h02100000);
		foreach (rows[i]) begin
			rw(1'b0, rows[i].addr, rows[i].be, rows[i].wdata);
			rw(1'b1, rows[i].addr, 4'hf, 32'h0);
			chk(rd, rows[i].exp);
		end
		{mem_hit_i, io_hit_i, special_cyc_i, addr_par_err_i} <= 4'hf;
		{data_par_err_i, mst_req_i, mst_write_i} <= 3'h7;
		// Memory hits already active when the memory enable is set
		events(32'h0156, 32'h00000fde);
		events(32'h0010, 32'h00000200);
		events(32'h0000, 32'h00000000);
		mem_hit_i <= 1'b0;
		events(32'h0002, 32'h00000080);
		clk_en_i <= 1'b0;
		mem_hit_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk({31'h0, mem_claim_o}, 32'h0);
		clk_en_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, mem_claim_o}, 32'h1);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rw(1'b1, cfg_header_pkg::OFF_COMMAND, 4'hf, 32'h0);
		chk(rd, 32'h02100000);
		conclude();
	end
endmodule : cfg_header_tb_top
